// ### src/mia_ctrl.sv
// Maskable interrupt acknowledge controller with Wishbone register slave
//
// Overview of operation
// - A maskable request is eligible only while its pending flag is 1 and its mask flag is 0.
// - An eligible maskable request is vectored only while the global enable is 1, else it stays pending.
// - From request to service start takes 9 to 19 CPU clocks, set by the core's instruction lengths.
// - The longest wait arises when the request comes just before a bit-test-and-branch instruction.
// - Requests eligible together are taken one at a time, highest priority flag first.
// - A request not yet taken stays pending and is taken once the conditions hold.
// - On acknowledge the status word then the program counter are stacked, enable clears, vector loads.
// - A flag set by clock n-1 of an n-clock instruction is taken right after that instruction.
// - A flag set in the final clock of an instruction waits until the next instruction completes.
// - While an instruction touches a flag or mask register all requests are held.
// - That hold covers maskable, non-maskable and external requests and lasts to instruction end.
// - Nesting during service follows the priority order.
// - A new maskable request nests only after the enable instruction, else it waits for the service to end.
// - A non-maskable request ignores the global enable and beats every maskable request.
// - Reset sets both mask registers to all ones.
`timescale 1ns/1ns
module mia_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Peripheral request sources, one-cycle pulses
  input wire logic [15:0] req_in,
  input wire logic nmi_req,
  // Core status
  input wire logic instr_done,
  input wire logic reg_hold,
  input wire logic ei_instr,
  input wire logic di_instr,
  input wire logic return_from_interrupt_instr_done,
  input wire logic return_from_interrupt_instr_ie,
  // Acknowledge to core
  output logic int_ack,
  output logic int_nmi,
  output logic [4:0] vec_idx,
  output logic push_psw,
  output logic push_pc,
  output logic pc_load,
  output logic [15:0] vec_addr,
  output logic global_int_enable,
  output logic [3:0] service_depth,
  // Bus interrupt
  output logic irq
);

  // Whole state of the block
  typedef struct packed {
    logic [15:0] req;
    logic [15:0] mask;
    logic [15:0] prio;
    logic gie;
    logic nmi_pend;
    logic hold;
    mia_pkg::mia_seq_e seq;
    logic [7:0] lvl;
    logic [3:0] depth;
    logic [2:0] evt;
    logic [2:0] evt_mask;
    logic ack;
    logic [31:0] rdat;
    logic int_ack;
    logic int_nmi;
    logic push_psw;
    logic push_pc;
    logic pc_load;
    logic [4:0] vec_idx;
    logic [15:0] vec_addr;
    logic irq;
  } mia_state_s;

  mia_state_s r;
  mia_state_s next_r;

  // Arbiter results
  logic [15:0] elig;
  logic allow_low;
  logic sel_found;
  logic [3:0] sel_idx;
  logic sel_hi;

  // Address of a flag or mask register; such an access freezes acknowledge
  function automatic logic mia_is_flagmask(input logic [7:0] adr);
    mia_is_flagmask = (adr == mia_pkg::OFS_REQ_LO) || (adr == mia_pkg::OFS_REQ_HI) ||
                      (adr == mia_pkg::OFS_MASK_LO) || (adr == mia_pkg::OFS_MASK_HI);
  endfunction

  // Vector table entry address, two bytes per entry
  function automatic logic [15:0] mia_vec(input logic [4:0] idx);
    mia_vec = mia_pkg::VEC_BASE + {10'h000, idx, 1'b0};
  endfunction

  // Eligibility and nesting filter
  assign elig = r.req & ~r.mask;
  // Inside a high-priority service only high-priority requests may nest
  assign allow_low = (r.depth == 4'h0) || !r.lvl[0];

  // Priority selection
  mia_arbiter u_arb (
    .elig(elig),
    .prio(r.prio),
    .allow_low(allow_low),
    .found(sel_found),
    .idx(sel_idx),
    .hi(sel_hi)
  );

  // Next-state logic
  always_comb begin
    logic [7:0] adr;
    logic hit;
    logic wr;
    logic boundary;
    logic take_nmi;
    logic take_mi;
    logic [15:0] req_clr;
    logic [2:0] ev;
    logic [2:0] w1c;
    logic [4:0] mi_vec;
    adr = {wb_adr_i[7:2], 2'b00};
    hit = 1'b0;
    wr = 1'b0;
    boundary = 1'b0;
    take_nmi = 1'b0;
    take_mi = 1'b0;
    req_clr = 16'h0000;
    ev = 3'h0;
    w1c = 3'h0;
    mi_vec = 5'h00;
    next_r = r;

    // Strobes last one cycle
    next_r.int_ack = 1'b0;
    next_r.int_nmi = 1'b0;
    next_r.push_psw = 1'b0;
    next_r.push_pc = 1'b0;
    next_r.pc_load = 1'b0;

    // Bus: answer one cycle after the request, drop ack the cycle after
    hit = wb_cyc_i && wb_stb_i && !r.ack;
    // Write lands at the edge where the master sees ack, so a cycle dropped early writes nothing
    wr = wb_cyc_i && wb_stb_i && r.ack && wb_we_i && wb_sel_i[0];
    next_r.ack = hit;
    next_r.rdat = 32'h0000_0000;
    if (hit && !wb_we_i) begin
      case (adr)
        mia_pkg::OFS_REQ_LO: next_r.rdat[7:0] = r.req[7:0];
        mia_pkg::OFS_REQ_HI: next_r.rdat[7:0] = r.req[15:8];
        mia_pkg::OFS_MASK_LO: next_r.rdat[7:0] = r.mask[7:0];
        mia_pkg::OFS_MASK_HI: next_r.rdat[7:0] = r.mask[15:8];
        mia_pkg::OFS_PRIO_LO: next_r.rdat[7:0] = r.prio[7:0];
        mia_pkg::OFS_PRIO_HI: next_r.rdat[7:0] = r.prio[15:8];
        mia_pkg::OFS_CTRL: next_r.rdat[mia_pkg::CTRL_GIE_BIT] = r.gie;
        mia_pkg::OFS_STATUS: begin
          next_r.rdat[mia_pkg::ST_VEC_LSB +: 5] = r.vec_idx;
          next_r.rdat[mia_pkg::ST_NMI_BIT] = r.nmi_pend;
          next_r.rdat[mia_pkg::ST_HOLD_BIT] = r.hold;
          next_r.rdat[mia_pkg::ST_GIE_BIT] = r.gie;
          next_r.rdat[mia_pkg::ST_DEPTH_LSB +: 4] = r.depth;
        end
        mia_pkg::OFS_EVT: next_r.rdat[2:0] = r.evt;
        mia_pkg::OFS_EVT_MASK: next_r.rdat[2:0] = r.evt_mask;
        default: next_r.rdat = 32'h0000_0000; // Unmapped reads zero, still acked
      endcase
    end

    // Hold from a flag or mask access lasts until the instruction ends
    if (instr_done) begin
      next_r.hold = 1'b0;
    end
    if (hit && mia_is_flagmask(adr)) begin
      next_r.hold = 1'b1;
    end

    // Boundary decision uses registered flags, so a flag set in the
    // final clock is only seen at the next boundary
    // Only instruction ends are boundaries, so latency rides on instruction length
    boundary = instr_done && (r.seq == mia_pkg::MIA_IDLE) && !r.hold && !reg_hold;
    take_nmi = boundary && r.nmi_pend;
    take_mi = boundary && !r.nmi_pend && r.gie && sel_found;
    mi_vec = 5'({1'b0, sel_idx}) + 5'h01;
    if (take_mi) begin
      req_clr = 16'h0001 << sel_idx;
    end

    // Software writes to the flag, mask, priority, control and event registers
    if (wr) begin
      case (adr)
        mia_pkg::OFS_REQ_LO: next_r.req[7:0] = wb_dat_i[7:0];
        mia_pkg::OFS_REQ_HI: next_r.req[15:8] = wb_dat_i[7:0];
        mia_pkg::OFS_MASK_LO: next_r.mask[7:0] = wb_dat_i[7:0];
        mia_pkg::OFS_MASK_HI: next_r.mask[15:8] = wb_dat_i[7:0];
        mia_pkg::OFS_PRIO_LO: next_r.prio[7:0] = wb_dat_i[7:0];
        mia_pkg::OFS_PRIO_HI: next_r.prio[15:8] = wb_dat_i[7:0];
        mia_pkg::OFS_CTRL: next_r.gie = wb_dat_i[mia_pkg::CTRL_GIE_BIT];
        mia_pkg::OFS_EVT: w1c = wb_dat_i[2:0];
        mia_pkg::OFS_EVT_MASK: next_r.evt_mask = wb_dat_i[2:0];
        default: next_r.evt_mask = next_r.evt_mask; // Unmapped writes are ignored
      endcase
    end

    // Pending flags: a new request wins over any clear in the same cycle
    ev[mia_pkg::EVT_LOST] = |(req_in & r.req);
    next_r.req = (next_r.req & ~req_clr) | req_in;

    // Non-maskable pending latch, set wins over its acknowledge
    if (take_nmi) begin
      next_r.nmi_pend = 1'b0;
    end
    if (nmi_req) begin
      next_r.nmi_pend = 1'b1;
    end

    // Global enable from the core's instructions
    if (ei_instr) begin
      next_r.gie = 1'b1;
    end
    if (di_instr) begin
      next_r.gie = 1'b0;
    end
    if (return_from_interrupt_instr_done) begin
      next_r.gie = return_from_interrupt_instr_ie;
      if (r.depth != 4'h0) begin
        next_r.depth = r.depth - 4'h1;
        next_r.lvl = {1'b0, r.lvl[7:1]};
      end
    end

    // Acknowledge: stack status word, then counter, then load the vector
    if (take_nmi || take_mi) begin
      next_r.gie = 1'b0;
      next_r.int_ack = 1'b1;
      next_r.int_nmi = take_nmi;
      next_r.push_psw = 1'b1;
      next_r.seq = mia_pkg::MIA_PUSH_PC;
      next_r.vec_idx = take_nmi ? mia_pkg::NMI_VEC : mi_vec;
      next_r.vec_addr = take_nmi ? mia_vec(mia_pkg::NMI_VEC) : mia_vec(mi_vec);
      // Saturate so deep nesting cannot wrap the depth count
      if (next_r.depth != mia_pkg::DEPTH_MAX) begin
        next_r.depth = next_r.depth + 4'h1;
      end
      next_r.lvl = {next_r.lvl[6:0], take_nmi || sel_hi};
    end
    ev[mia_pkg::EVT_MACK] = take_mi;
    ev[mia_pkg::EVT_NACK] = take_nmi;

    // Stacking sequence; the core must not report a boundary meanwhile
    case (r.seq)
      mia_pkg::MIA_IDLE: begin
      end
      mia_pkg::MIA_PUSH_PC: begin
        next_r.push_pc = 1'b1;
        next_r.seq = mia_pkg::MIA_LOAD_PC;
      end
      mia_pkg::MIA_LOAD_PC: begin
        next_r.pc_load = 1'b1;
        next_r.seq = mia_pkg::MIA_IDLE;
      end
      default: begin
        next_r.seq = mia_pkg::MIA_IDLE;
      end
    endcase

    // Sticky events, set wins over write-one-to-clear
    next_r.evt = (r.evt & ~w1c) | ev;
    next_r.irq = |(next_r.evt & next_r.evt_mask);
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      r <= '0;
      r.req <= {mia_pkg::REQ_RST, mia_pkg::REQ_RST};
      r.mask <= {mia_pkg::MASK_RST, mia_pkg::MASK_RST};
      r.prio <= {mia_pkg::PRIO_RST, mia_pkg::PRIO_RST};
      r.gie <= mia_pkg::GIE_RST;
      r.seq <= mia_pkg::MIA_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from the state register
  assign wb_dat_o = r.rdat;
  assign wb_ack_o = r.ack;
  assign int_ack = r.int_ack;
  assign int_nmi = r.int_nmi;
  assign vec_idx = r.vec_idx;
  assign push_psw = r.push_psw;
  assign push_pc = r.push_pc;
  assign pc_load = r.pc_load;
  assign vec_addr = r.vec_addr;
  assign global_int_enable = r.gie;
  assign service_depth = r.depth;
  assign irq = r.irq;
endmodule // mia_ctrl

// ### shared/mia_pkg.sv
// Constants and types shared by the maskable interrupt acknowledge block
package mia_pkg;
  // Request sources
  localparam int NREQ = 16;
  // Register byte offsets on the Wishbone slave
  localparam logic [7:0] OFS_REQ_LO = 8'h00;
  localparam logic [7:0] OFS_REQ_HI = 8'h04;
  localparam logic [7:0] OFS_MASK_LO = 8'h08;
  localparam logic [7:0] OFS_MASK_HI = 8'h0C;
  localparam logic [7:0] OFS_PRIO_LO = 8'h10;
  localparam logic [7:0] OFS_PRIO_HI = 8'h14;
  localparam logic [7:0] OFS_CTRL = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [7:0] OFS_EVT = 8'h20;
  localparam logic [7:0] OFS_EVT_MASK = 8'h24;
  // Reset values
  localparam logic [7:0] REQ_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'hFF;
  localparam logic [7:0] PRIO_RST = 8'h00;
  localparam logic GIE_RST = 1'b0;
  // Field positions
  localparam int CTRL_GIE_BIT = 0;
  localparam int ST_VEC_LSB = 0;
  localparam int ST_NMI_BIT = 8;
  localparam int ST_HOLD_BIT = 9;
  localparam int ST_GIE_BIT = 10;
  localparam int ST_DEPTH_LSB = 12;
  localparam int EVT_MACK = 0;
  localparam int EVT_NACK = 1;
  localparam int EVT_LOST = 2;
  localparam int NEVT = 3;
  // Vector table: base and non-maskable entry
  localparam logic [15:0] VEC_BASE = 16'h0002;
  localparam logic [4:0] NMI_VEC = 5'h00;
  // Nesting depth ceiling
  localparam logic [3:0] DEPTH_MAX = 4'h8;
  // Latency window from request to service start, in CPU clocks
  localparam int LAT_MIN_CLK = 9;
  localparam int LAT_MAX_CLK = 19;
  // Acknowledge sequence
  typedef enum logic [1:0] {
    MIA_IDLE,
    MIA_PUSH_PC,
    MIA_LOAD_PC
  } mia_seq_e;
endpackage

// ### src/mia_arbiter.sv
// Priority selector among eligible maskable requests
`timescale 1ns/1ns
module mia_arbiter (
  // Candidates
  input wire logic [15:0] elig,
  input wire logic [15:0] prio,
  input wire logic allow_low,
  // Winner
  output logic found,
  output logic [3:0] idx,
  output logic hi
);
  // High-priority group beats low; within a group the lowest index wins
  always_comb begin
    found = 1'b0;
    idx = 4'h0;
    hi = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      if (elig[i] && !prio[i] && allow_low) begin
        found = 1'b1;
        idx = 4'(i);
        hi = 1'b0;
      end
    end
    // Second pass overrides, so a high-priority candidate always wins
    for (int i = 15; i >= 0; i--) begin
      if (elig[i] && prio[i]) begin
        found = 1'b1;
        idx = 4'(i);
        hi = 1'b1;
      end
    end
  end
endmodule // mia_arbiter

// ### tb/mia_core_model.sv
// Core sequencer model that marks instruction boundaries
`timescale 1ns/1ns
module mia_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Instruction length in clocks, 4 to 10
  input wire logic [3:0] len,
  // Final clock of each instruction
  output logic instr_done
);
  logic [3:0] cnt;
  logic [3:0] cur;
  // Length latched at instruction start, so a change never cuts one short
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt <= 4'h0;
      cur <= 4'h4;
    end else if (cnt == cur - 4'h1) begin
      cnt <= 4'h0;
      cur <= len;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
  // Boundary strobe; 10 clocks stands for the bit-test branch worst case
  assign instr_done = !srst && (cnt == cur - 4'h1);
endmodule // mia_core_model

// ### tb/mia_monitor.sv
// Concurrent checks on the acknowledge side of the controller
`timescale 1ns/1ns
module mia_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Core status
  input wire logic instr_done,
  input wire logic reg_hold,
  // Acknowledge outputs
  input wire logic int_ack,
  input wire logic int_nmi,
  input wire logic [4:0] vec_idx,
  input wire logic push_psw,
  input wire logic push_pc,
  input wire logic pc_load,
  input wire logic [15:0] vec_addr,
  input wire logic global_int_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Stacking order: status word, then counter, then vector load
  sequence stack_steps;
    push_psw ##1 push_pc ##1 pc_load;
  endsequence
  ack_order_a: assert property (int_ack |-> stack_steps)
    else $error("stacking order broken");
  gie_clear_a: assert property (int_ack |-> !global_int_enable)
    else $error("enable not cleared on acknowledge");
  vec_load_a: assert property (pc_load |-> vec_addr == mia_pkg::VEC_BASE + {10'h000, vec_idx, 1'b0})
    else $error("vector address wrong");
  ack_edge_a: assert property (int_ack |-> $past(instr_done))
    else $error("acknowledge off a boundary");
  ack_single_a: assert property (int_ack |=> !int_ack ##1 !int_ack)
    else $error("acknowledge not a single strobe");
  hold_block_a: assert property (instr_done && reg_hold |=> !int_ack)
    else $error("acknowledge during hold");
  gie_gate_a: assert property (int_ack && !int_nmi |-> $past(global_int_enable))
    else $error("maskable taken while disabled");
  nmi_vec_a: assert property (int_ack && int_nmi |-> vec_idx == 5'h00)
    else $error("non-maskable vector wrong");
  mask_range_a: assert property (int_ack && !int_nmi |-> vec_idx != 5'h00 && vec_idx <= 5'h10)
    else $error("maskable vector out of range");
endmodule // mia_monitor
bind mia_ctrl mia_monitor u_mon (.clk(clk), .srst(srst), .instr_done(instr_done), .reg_hold(reg_hold),
  .int_ack(int_ack), .int_nmi(int_nmi), .vec_idx(vec_idx), .push_psw(push_psw), .push_pc(push_pc),
  .pc_load(pc_load), .vec_addr(vec_addr), .global_int_enable(global_int_enable));

// ### tb/tb_top.sv
// Self-checking bench for the interrupt acknowledge controller
`timescale 1ns/1ns
module tb_top;
  logic clk = 1'b0, srst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, nmi = 1'b0, done, hold = 1'b0;
  logic ei = 1'b0, di = 1'b0, return_from_interrupt_instr = 1'b0, return_from_interrupt_instr_ie = 1'b0, int_ack, int_nmi, gie, irq;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic [15:0] req = 16'h0, vec_addr;
  logic [4:0] vec_idx;
  logic [3:0] len = 4'h4, depth;
  int err_total = 0, num_checks = 0;
  always #20 clk = ~clk;
  // Design and core model
  mia_ctrl uut (.clk(clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .req_in(req), .nmi_req(nmi),
    .instr_done(done), .reg_hold(hold), .ei_instr(ei), .di_instr(di), .return_from_interrupt_instr_done(return_from_interrupt_instr), .return_from_interrupt_instr_ie(return_from_interrupt_instr_ie),
    .int_ack(int_ack), .int_nmi(int_nmi), .vec_idx(vec_idx), .push_psw(), .push_pc(), .pc_load(),
    .vec_addr(vec_addr), .global_int_enable(gie), .service_depth(depth), .irq(irq));
  mia_core_model core (.clk(clk), .srst(srst), .len(len), .instr_done(done));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Classic cycle; ack and read data are taken at the rising edge that sees ack high, then released
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    // A slave that never answers ends the run as a failure
    if (ack !== 1'b1) begin
      err_total++;
      print_verdict();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, exp, q);
  endtask
  task automatic irq_is(input logic exp);
    @(negedge clk);
    chk("irq", {31'h0, exp}, {31'h0, irq});
  endtask
  // One-cycle pulses of requests and core events
  task automatic strobe(input logic [15:0] r, input logic n, input logic e, input logic t, input logic ie);
    @(posedge clk);
    req <= r;
    nmi <= n;
    ei <= e;
    return_from_interrupt_instr <= t;
    return_from_interrupt_instr_ie <= ie;
    @(posedge clk);
    req <= 16'h0;
    nmi <= 1'b0;
    ei <= 1'b0;
    return_from_interrupt_instr <= 1'b0;
  endtask
  // Watch n cycles for an acknowledge and its {nmi, vector} code
  task automatic watch(input int n, input logic exp_hit, input logic [5:0] exp_code);
    logic hit;
    logic [5:0] code;
    hit = 1'b0;
    code = 6'h00;
    repeat (n) begin
      @(negedge clk);
      if (int_ack === 1'b1) begin
        hit = 1'b1;
        code = {int_nmi, vec_idx};
      end
    end
    chk("acknowledge", {31'h0, exp_hit}, {31'h0, hit});
    if (exp_hit) chk("vector", {26'h0, exp_code}, {26'h0, code});
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Watchdog far beyond the few hundred cycles the tests need
  initial begin
    #400000;
    err_total++;
    print_verdict();
  end
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    rd("mask low", mia_pkg::OFS_MASK_LO, 32'h0000_00FF);
    rd("mask high", mia_pkg::OFS_MASK_HI, 32'h0000_00FF);
    rd("unmapped", 8'h30, 32'h0);
    strobe(16'h0008, 1'b0, 1'b0, 1'b0, 1'b0);
    watch(20, 1'b0, 6'h00);
    bus(1'b1, mia_pkg::OFS_MASK_LO, 32'h0000_00F7);
    watch(20, 1'b0, 6'h00);
    rd("pending low", mia_pkg::OFS_REQ_LO, 32'h0000_0008);
    strobe(16'h0, 1'b0, 1'b1, 1'b0, 1'b0);
    watch(20, 1'b1, 6'h04);
    chk("vector address", 32'h0000_000A, {16'h0, vec_addr});
    chk("enable", 32'h0, {31'h0, gie});
    // Event interrupt: masked, raised, cleared by writing one
    bus(1'b1, mia_pkg::OFS_EVT_MASK, 32'h0);
    irq_is(1'b0);
    bus(1'b1, mia_pkg::OFS_EVT_MASK, 32'h0000_0001);
    irq_is(1'b1);
    bus(1'b1, mia_pkg::OFS_EVT, 32'h0000_0001);
    irq_is(1'b0);
    strobe(16'h0, 1'b0, 1'b0, 1'b1, 1'b0);
    // Two at once: high-priority source 9 first, low one may not nest
    bus(1'b1, mia_pkg::OFS_PRIO_HI, 32'h0000_0002);
    bus(1'b1, mia_pkg::OFS_MASK_HI, 32'h0000_00FD);
    bus(1'b1, mia_pkg::OFS_MASK_LO, 32'h0000_00FB);
    strobe(16'h0204, 1'b0, 1'b1, 1'b0, 1'b0);
    watch(20, 1'b1, 6'h0A);
    strobe(16'h0, 1'b0, 1'b1, 1'b0, 1'b0);
    watch(20, 1'b0, 6'h00);
    chk("depth", 32'h0000_0001, {28'h0, depth});
    strobe(16'h0, 1'b0, 1'b0, 1'b1, 1'b1);
    watch(20, 1'b1, 6'h03);
    strobe(16'h0, 1'b0, 1'b0, 1'b1, 1'b0);
    // Non-maskable held by a register access, then taken with enable off
    @(posedge clk);
    hold <= 1'b1;
    strobe(16'h0, 1'b1, 1'b0, 1'b0, 1'b0);
    watch(20, 1'b0, 6'h00);
    @(posedge clk);
    hold <= 1'b0;
    watch(20, 1'b1, 6'h20);
    // Longest instructions: service must still start within 19 clocks
    @(posedge clk);
    len <= 4'hA;
    strobe(16'h0, 1'b0, 1'b0, 1'b1, 1'b1);
    strobe(16'h0004, 1'b0, 1'b0, 1'b0, 1'b0);
    watch(19, 1'b1, 6'h03);
    // Request in the final clock of a 10-clock instruction waits for the next one to end
    strobe(16'h0, 1'b0, 1'b0, 1'b1, 1'b1);
    do @(negedge clk); while (done !== 1'b1);
    repeat (10) @(posedge clk);
    req <= 16'h0004;
    @(posedge clk);
    req <= 16'h0;
    watch(9, 1'b0, 6'h00);
    watch(12, 1'b1, 6'h03);
    // Disable instruction clears the restored enable again
    strobe(16'h0, 1'b0, 1'b0, 1'b1, 1'b1);
    @(negedge clk);
    chk("enable restored", 32'h0000_0001, {31'h0, gie});
    @(posedge clk);
    di <= 1'b1;
    @(posedge clk);
    di <= 1'b0;
    @(negedge clk);
    chk("enable after disable", 32'h0, {31'h0, gie});
    print_verdict();
  end
endmodule // tb_top
